// *** scrb_readback.sv ***
// Serial readback of the system control register word.
// Assumes the serial clock, frame select and data pins come from outside
// the core clock domain and run far slower than the core clock.
//
// Operation
// R1: Readback word is 24 bits, bit 23 most significant.
// R2: Word tag bits 23 and 22 are both zero for this register.
// R3: Bits 21..18 report current-limit enables of channels 3..0.
// R4: Each current-limit bit holds the latest write from either register.
// R5: Bits 17..14 report comparator output enables of channels 3..0.
// R6: Each comparator output enable holds the latest write from either path.
// R7: Bit 13 reports the overall comparator function enable.
// R8: Bit 12 reports the per-channel ground sense selection.
// R9: Bits 11 and 10 report shield and limit fault alarm enables.
// R10: Bit 9 reports the internal resistor switch state.
// R11: Bit 8 reports the shield drive amplifier enable.
// R12: Bits 7 and 6 report the measure output range code.
// R13: Host requests with read flag set, channel and mode bits clear.
// R14: Word loads into the top of 29 bits, five zeros below, rising shift.
// R15: Bits 5..3 report thermal shutdown enable and trip select.
// R16: Bit 2 reports unlatched alarms; bit 1 reads zero.
// R17: All fields are sampled once when the read request is accepted.
`timescale 1ns/10ps
`default_nettype none
module scrb_readback
  import scrb_pkg::*;
(
  // Clock and reset.
  input  wire logic      ref_clk_i,
  input  wire logic      rst_b_i,
  // Serial pins.
  input  wire logic      sclk_i,
  input  wire logic      frame_sel_b_i,
  input  wire logic      sdi_i,
  output logic           sdo_o,
  // Enable writes from the two register paths.
  input  wire scrb_wr_t  sys_cl_wr_i,
  input  wire scrb_wr_t  pmu_cl_wr_i,
  input  wire scrb_wr_t  sys_cpo_wr_i,
  input  wire scrb_wr_t  pmu_cpo_wr_i,
  // Reported settings.
  input  wire scrb_cfg_t cfg_i
);

  function automatic logic [3:0] merge(input logic [3:0] cur,
                                       input scrb_wr_t   a,
                                       input scrb_wr_t   b);
    logic [3:0] r;
    r = cur;
    if (a.wr) begin
      r = (r & ~a.mask) | (a.val & a.mask);
    end
    if (b.wr) begin
      r = (r & ~b.mask) | (b.val & b.mask);
    end
    return r;
  endfunction

  function automatic logic [WORD_W-1:0] pack_word(input scrb_cfg_t c,
                                                  input logic [3:0] cl,
                                                  input logic [3:0] cpo);
    logic [WORD_W-1:0] w;
    w = '0;
    w[TAG_POS+:2]     = WORD_TAG;                      // see R2
    w[CL_POS+:4]      = cl;                            // see R3
    w[CPO_POS+:4]     = cpo;                           // see R5
    w[CMP_EN_POS]     = c.comparator_function_enable;  // see R7
    w[GSENSE_POS]     = c.per_channel_ground_sense;    // see R8
    w[SHD_ALM_POS]    = c.shield_fault_alarm_enable;   // see R9
    w[LIM_ALM_POS]    = c.limit_fault_alarm_enable;    // see R9
    w[RSW_POS]        = c.internal_resistor_switch;    // see R10
    w[AMP_POS]        = c.shield_amp_enable;           // see R11
    w[SCALE_POS+:2]   = c.measure_out_scale;           // see R12
    w[TMP_EN_POS]     = c.thermal_shutdown_enable;     // see R15
    w[TMP_SEL_POS+:2] = c.thermal_trip_select;         // see R15
    w[UNLATCH_POS]    = c.alarm_unlatched;             // see R16
    return w;
  endfunction

  // Reset release through two flip-flops.
  logic [1:0] rst_sync_q;
  logic       rst_sync_b;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_sync_q[1];

  // Pin synchronisers; stage one feeds only stage two.
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [1:0] s3_q;

  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s1_q <= 3'h3;
      s2_q <= 3'h3;
      s3_q <= 2'h3;
    end else begin
      s1_q <= {sdi_i, frame_sel_b_i, sclk_i};
      s2_q <= s1_q;
      s3_q <= s2_q[1:0];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  logic sdi_s;

  assign sclk_rise   = s2_q[0] & ~s3_q[0];
  assign sclk_fall   = ~s2_q[0] & s3_q[0];
  assign frame_start = ~s2_q[1] & s3_q[1];
  assign frame_end   = s2_q[1] & ~s3_q[1];
  assign sdi_s       = s2_q[2];

  // Frame state, command capture, held enables and output shift register.
  scrb_state_t      st_q,  st_d;
  logic [CMD_W-1:0] rx_q,  rx_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CMD_W-1:0] tx_q,  tx_d;
  logic [3:0]       cl_q,  cl_d;
  logic [3:0]       cpo_q, cpo_d;
  logic             load;

  // The request takes effect only on a frame of at least 29 bits; a short or
  // aborted frame loads no new word, but its rising edges still shift tx_q.
  assign load = (st_q == ST_FRAME) && frame_end && (cnt_q == CMD_BITS)
                && (rx_q[CMD_W-1 -: 7] == CMD_RD_SYSCTL);   // see R13

  always_comb begin
    st_d  = st_q;
    rx_d  = rx_q;
    cnt_d = cnt_q;
    tx_d  = tx_q;
    cl_d  = merge(cl_q, sys_cl_wr_i, pmu_cl_wr_i);        // see R4
    cpo_d = merge(cpo_q, sys_cpo_wr_i, pmu_cpo_wr_i);     // see R6
    unique case (st_q)
      ST_IDLE: begin
        if (frame_start) begin
          st_d  = ST_FRAME;
          cnt_d = '0;
        end
      end
      ST_FRAME: begin
        if (frame_end) begin
          st_d = ST_IDLE;
        end else if (sclk_fall) begin
          rx_d = {rx_q[CMD_W-2:0], sdi_s};
          if (cnt_q != CMD_BITS) begin
            cnt_d = cnt_q + 5'h01;
          end
        end
        if (sclk_rise && !frame_end) begin
          tx_d = {tx_q[CMD_W-2:0], 1'b0};                  // see R14
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    // A single snapshot keeps the word coherent while it shifts out.
    if (load) begin
      tx_d = {pack_word(cfg_i, cl_q, cpo_q), {PAD_W{1'b0}}}; // see R1, R14, R17
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_q  <= ST_IDLE;
      rx_q  <= TX_RST;
      cnt_q <= '0;
      tx_q  <= TX_RST;
      cl_q  <= CL_RST;
      cpo_q <= CPO_RST;
    end else begin
      st_q  <= st_d;
      rx_q  <= rx_d;
      cnt_q <= cnt_d;
      tx_q  <= tx_d;
      cl_q  <= cl_d;
      cpo_q <= cpo_d;
    end
  end

  assign sdo_o = tx_q[CMD_W-1];

  property p_tag;
    @(posedge ref_clk_i) disable iff (!rst_sync_b)
    load |=> tx_q[28:27] == 2'h0;
  endproperty
  a_tag: assert property (p_tag) else $error("tag not zero"); // see R2

  property p_cl;
    @(posedge ref_clk_i) disable iff (!rst_sync_b)
    load |=> tx_q[26:23] == $past(cl_q);
  endproperty
  a_cl: assert property (p_cl) else $error("limit bits wrong"); // see R3

  property p_cl_wr;
    @(posedge ref_clk_i) disable iff (!rst_sync_b)
    (sys_cl_wr_i.wr && sys_cl_wr_i.mask == 4'hF && !pmu_cl_wr_i.wr)
      |=> cl_q == $past(sys_cl_wr_i.val);
  endproperty
  a_cl_wr: assert property (p_cl_wr) else $error("limit write lost"); // see R4

  property p_cpo;
    @(posedge ref_clk_i) disable iff (!rst_sync_b)
    load |=> tx_q[22:19] == $past(cpo_q);
  endproperty
  a_cpo: assert property (p_cpo) else $error("cmp out bits wrong"); // see R5

  property p_cpo_wr;
    @(posedge ref_clk_i) disable iff (!rst_sync_b)
    (pmu_cpo_wr_i.wr && pmu_cpo_wr_i.mask == 4'hF)
      |=> cpo_q == $past(pmu_cpo_wr_i.val);
  endproperty
  a_cpo_wr: assert property (p_cpo_wr) else $error("cmp write lost"); // see R6

  property p_mid;
    @(posedge ref_clk_i) disable iff (!rst_sync_b)
    load |=> tx_q[18:11] == {$past(cfg_i.comparator_function_enable),
      $past(cfg_i.per_channel_ground_sense),
      $past(cfg_i.shield_fault_alarm_enable),
      $past(cfg_i.limit_fault_alarm_enable),
      $past(cfg_i.internal_resistor_switch),
      $past(cfg_i.shield_amp_enable), $past(cfg_i.measure_out_scale)};
  endproperty
  a_mid: assert property (p_mid) else $error("setting bits wrong"); // see R7

  property p_low;
    @(posedge ref_clk_i) disable iff (!rst_sync_b)
    load |=> tx_q[10:5] == {$past(cfg_i.thermal_shutdown_enable),
      $past(cfg_i.thermal_trip_select), $past(cfg_i.alarm_unlatched),
      2'h0};
  endproperty
  a_low: assert property (p_low) else $error("thermal bits wrong"); // see R15

  property p_pad;
    @(posedge ref_clk_i) disable iff (!rst_sync_b)
    load |=> tx_q[4:0] == 5'h00 ##1 tx_q[4:0] == 5'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("pad not zero"); // see R14

  property p_hold;
    @(posedge ref_clk_i) disable iff (!rst_sync_b)
    (!load && !(sclk_rise && st_q == ST_FRAME)) |=> $stable(tx_q);
  endproperty
  a_hold: assert property (p_hold) else $error("word changed"); // see R17

  property p_shift;
    @(posedge ref_clk_i) disable iff (!rst_sync_b)
    (sclk_rise && st_q == ST_FRAME && !frame_end && !load)
      |=> tx_q == {$past(tx_q[27:0]), 1'b0};
  endproperty
  a_shift: assert property (p_shift) else $error("bad shift"); // see R1

endmodule
`default_nettype wire

// *** scrb_pkg.sv ***
// Constants, field layout and carrier types for the readback word of the
// system control register.
// Assumes a single core clock; the serial pins are sampled, not clocked on.
`default_nettype none
package scrb_pkg;

  // Serial frame and word sizes.
  localparam int unsigned CMD_W  = 29;
  localparam int unsigned WORD_W = 24;
  localparam int unsigned PAD_W  = 5;
  localparam int unsigned CNT_W  = 5;

  // Field positions inside the 24-bit readback word.
  localparam int unsigned TAG_POS     = 22;
  localparam int unsigned CL_POS      = 18;
  localparam int unsigned CPO_POS     = 14;
  localparam int unsigned CMP_EN_POS  = 13;
  localparam int unsigned GSENSE_POS  = 12;
  localparam int unsigned SHD_ALM_POS = 11;
  localparam int unsigned LIM_ALM_POS = 10;
  localparam int unsigned RSW_POS     = 9;
  localparam int unsigned AMP_POS     = 8;
  localparam int unsigned SCALE_POS   = 6;
  localparam int unsigned TMP_EN_POS  = 5;
  localparam int unsigned TMP_SEL_POS = 3;
  localparam int unsigned UNLATCH_POS = 2;

  // Tag value of this word, and the upper command bits that request it.
  localparam logic [1:0] WORD_TAG        = 2'h0;
  localparam logic [6:0] CMD_RD_SYSCTL   = 7'h40;
  localparam logic [CNT_W-1:0] CMD_BITS  = 5'h1D;

  // Reset values of the held enables and of the output shift register.
  localparam logic [3:0]       CL_RST  = 4'h0;
  localparam logic [3:0]       CPO_RST = 4'h0;
  localparam logic [CMD_W-1:0] TX_RST  = 29'h0000_0000;

  // Settings that are simply reported, grouped as one carrier.
  typedef struct packed {
    logic       comparator_function_enable;
    logic       per_channel_ground_sense;
    logic       shield_fault_alarm_enable;
    logic       limit_fault_alarm_enable;
    logic       internal_resistor_switch;
    logic       shield_amp_enable;
    logic [1:0] measure_out_scale;
    logic       thermal_shutdown_enable;
    logic [1:0] thermal_trip_select;
    logic       alarm_unlatched;
  } scrb_cfg_t;

  // One write to a four-channel enable group.
  typedef struct packed {
    logic       wr;
    logic [3:0] mask;
    logic [3:0] val;
  } scrb_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FRAME = 2'b10
  } scrb_state_t;

endpackage
`default_nettype wire

// *** scrb_host.sv ***
// Host serial controller model that frames read commands.
// Assumes the core clock paces every pin change it makes.
`timescale 1ns/10ps
`default_nettype none
module scrb_host (
  // Pacing clock.
  input  wire logic ref_clk_i,
  // Serial pins.
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      frame_sel_b_o,
  output logic      sdi_o
);
  // Half of the 80 ns serial period, in core clocks.
  localparam int HALF = 10;
  initial begin
    sclk_o = 1'b1;
    frame_sel_b_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Sends n command bits MSB first and collects sdo before each fall.
  task automatic xfer(input logic [28:0] cmd, input int n,
                      output logic [28:0] rx);
    rx = 29'h0000_0000;
    frame_sel_b_o <= 1'b0;
    wt(HALF);
    for (int i = 0; i < n; i++) begin
      sdi_o <= cmd[28-i];
      wt(HALF - 1);
      @(negedge ref_clk_i);
      rx[28-i] = sdo_i;
      @(posedge ref_clk_i);
      sclk_o <= 1'b0;
      wt(HALF);
      sclk_o <= 1'b1;
    end
    wt(HALF);
    frame_sel_b_o <= 1'b1;
    // The data line is not held after a frame, so it shows the inverse.
    sdi_o <= ~sdi_o;
    wt(HALF);
  endtask
endmodule
`default_nettype wire

// *** scrb_readback_test.sv ***
// Self-checking bench for the system control readback word.
// Assumes the host model in scrb_host.sv drives the serial pins.
`timescale 1ns/10ps
`default_nettype none
module scrb_readback_test;
  import scrb_pkg::*;
  // Read request: read flag set, channel and tag bits clear.
  localparam logic [28:0] RD  = 29'h1000_0000;
  localparam logic [28:0] BAD = 29'h1040_0000;
  logic        ref_clk, rst_b, sclk, frame_sel_b, sdi, sdo;
  scrb_wr_t    scl, pcl, scpo, pcpo;
  scrb_cfg_t   cfg;
  logic [28:0] rx;
  logic [3:0]  cl_m, cpo_m;
  int          fail_count = 0;
  int          checks_done = 0;
  scrb_readback scrb_readback_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .sclk_i(sclk), .frame_sel_b_i(frame_sel_b), .sdi_i(sdi), .sdo_o(sdo),
    .sys_cl_wr_i(scl), .pmu_cl_wr_i(pcl), .sys_cpo_wr_i(scpo),
    .pmu_cpo_wr_i(pcpo), .cfg_i(cfg));
  scrb_host scrb_host_inst (.ref_clk_i(ref_clk), .sdo_i(sdo),
    .sclk_o(sclk), .frame_sel_b_o(frame_sel_b), .sdi_o(sdi));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  function automatic logic [23:0] word();
    return {2'h0, cl_m, cpo_m, cfg, 2'h0};
  endfunction
  task automatic chk(input string what, input logic [23:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic rd(input string what);
    scrb_host_inst.xfer(RD, 29, rx);
    scrb_host_inst.xfer(RD, 29, rx);
    chk(what, rx[28:5], word());
    chk("pad", {19'h0, rx[4:0]}, 24'h00_0000);
  endtask
  task automatic wr(input scrb_wr_t a, b, c, d);
    @(posedge ref_clk);
    {scl, pcl, scpo, pcpo} <= {a, b, c, d};
    @(posedge ref_clk);
    {scl, pcl, scpo, pcpo} <= 36'h0_0000_0000;
  endtask
  task automatic t_fields();
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      cfg <= 12'((i < 12) ? 12'h001 << i : 12'h008 | ((i - 12) << 1));
      rd("field");
    end
    $display("done fields");
  endtask
  task automatic t_enables();
    wr('{1'b1, 4'hf, 4'ha}, '{1'b1, 4'h3, 4'h5},
       '{1'b1, 4'hf, 4'h5}, '{1'b0, 4'h0, 4'h0});
    cl_m = 4'h9;
    cpo_m = 4'h5;
    wr('{1'b0, 4'h0, 4'h0}, '{1'b0, 4'h0, 4'h0},
       '{1'b0, 4'h0, 4'h0}, '{1'b1, 4'h8, 4'hf});
    cpo_m = 4'hd;
    rd("first");
    wr('{1'b1, 4'hf, 4'h0}, '{1'b1, 4'h6, 4'hf},
       '{1'b1, 4'hf, 4'hf}, '{1'b1, 4'h1, 4'h0});
    cl_m = 4'h6;
    cpo_m = 4'he;
    rd("both");
    $display("done enables");
  endtask
  task automatic t_snap();
    logic [23:0] w;
    scrb_host_inst.xfer(RD, 29, rx);
    w = word();
    cfg <= 12'hfff;
    wr('{1'b1, 4'hf, 4'h1}, '{1'b0, 4'h0, 4'h0},
       '{1'b0, 4'h0, 4'h0}, '{1'b1, 4'hf, 4'h9});
    cl_m = 4'h1;
    cpo_m = 4'h9;
    scrb_host_inst.xfer(RD, 29, rx);
    chk("snap", rx[28:5], w);
    $display("done snapshot");
  endtask
  task automatic t_refuse();
    logic [23:0] w;
    scrb_host_inst.xfer(RD, 29, rx);
    w = word();
    @(posedge ref_clk);
    cfg <= 12'h5a6;
    scrb_host_inst.xfer(BAD, 29, rx);
    chk("bad", rx[28:5], w);
    scrb_host_inst.xfer(RD, 28, rx);
    chk("no bad", {23'h0, rx[28:5] === word()}, 24'h0);
    scrb_host_inst.xfer(RD, 29, rx);
    chk("no short", {23'h0, rx[28:5] === word()}, 24'h0);
    scrb_host_inst.xfer(RD, 29, rx);
    chk("reload", rx[28:5], word());
    $display("done refusal");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    {scl, pcl, scpo, pcpo} = 36'h0_0000_0000;
    cfg = 12'h000;
    cl_m = 4'h0;
    cpo_m = 4'h0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd("reset");
    $display("done reset");
    t_fields();
    t_enables();
    t_snap();
    t_refuse();
    give_verdict();
  end
  // About 30k core clocks are expected; 60k leaves a wide margin.
  initial begin
    #240_000;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
